// ---- hdl/expander_link.sv ----
// Link-side sequencer of the expander: pointer, pair alternation,
// and the toggle handshake towards the register core.
// Assumes a byte-level protocol engine clocked by linkClk.
`timescale 1ns/100ps
`default_nettype none
`include "serial_io_expander_regs_params.svh"

module expander_link
  import serial_io_expander_pkg::*;
(
  input  wire logic  linkClk,     // Link clock
  input  wire logic  rst_n,       // Core-domain reset, synced here
  input  wire logic  xferStart,   // Start or restart, address acked
  input  wire logic  xferRead,    // Direction with xferStart
  input  wire logic  xferStop,    // Stop seen
  input  wire logic  wrByteValid, // Written byte at ack edge
  input  wire byte_t wrByte,      // Written byte
  input  wire logic  rdByteReq,   // Next read byte wanted, ack edge
  input  wire logic  ackToggle,   // Core answer toggle
  input  wire byte_t rspData,     // Core read data
  output logic       reqToggle,   // Request toggle to core
  output logic       reqWrite,    // Request is a write
  output regIdx_t    reqIdx,      // Register index
  output byte_t      reqData,     // Write data
  output byte_t      rdData,      // Read byte for the engine
  output logic       rdValid,     // rdData fresh, one pulse
  output logic       linkBusy     // Request in flight
);

  logic    linkRst1_q, linkRstN_q;
  phase_e  phase_q;
  byte_t   pointer_q;
  regIdx_t accIdx_q, lastIdx_q;
  logic    presented_q;
  logic    ack1_q, ack2_q, ackSeen_q;
  logic    cmdTake, wrIssue, rdIssue, restartRead;

  // Reset release brought onto the link clock
  always_ff @(posedge linkClk) begin
    linkRst1_q <= rst_n;
    linkRstN_q <= linkRst1_q;
  end

  // Answer toggle synchroniser
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      ack1_q <= 1'b0;
      ack2_q <= 1'b0;
    end else begin
      ack1_q <= ackToggle;
      ack2_q <= ack1_q;
    end
  end

  // Byte events; busy drops data bytes but not the command byte, the engine must wait
  assign cmdTake     = wrByteValid && (phase_q == PH_CMD);
  assign wrIssue     = wrByteValid && (phase_q == PH_WRITE) && !linkBusy;
  assign rdIssue     = rdByteReq && (phase_q == PH_READ) && !linkBusy;
  assign restartRead = xferStart && (phase_q == PH_READ) && presented_q;

  // Transfer phase
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      phase_q <= PH_IDLE;
    end else if (xferStop) begin
      phase_q <= PH_IDLE;
    end else if (xferStart) begin
      phase_q <= xferRead ? PH_READ : PH_CMD;  // [R3]
    end else if (cmdTake) begin
      phase_q <= PH_WRITE;
    end
  end

  // Pointer: command byte, or the register read at a restart
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      pointer_q <= `RST_POINTER;
    end else if (cmdTake) begin
      pointer_q <= wrByte;  // [R1]
    end else if (restartRead) begin
      pointer_q[`PTR_IDX_MSB:`PTR_IDX_LSB] <= lastIdx_q;  // [R14]
    end
  end

  // Access index walks the pair after each accepted data byte
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      accIdx_q    <= 3'h0;
      lastIdx_q   <= 3'h0;
      presented_q <= 1'b0;
    end else if (restartRead) begin
      accIdx_q    <= lastIdx_q;  // [R14]
      presented_q <= 1'b0;
    end else if (xferStart) begin
      accIdx_q    <= pointer_q[`PTR_IDX_MSB:`PTR_IDX_LSB];  // [R4]
      presented_q <= 1'b0;
    end else if (cmdTake) begin
      accIdx_q <= wrByte[`PTR_IDX_MSB:`PTR_IDX_LSB];  // [R2]
    end else if (wrIssue || rdIssue) begin
      accIdx_q <= {accIdx_q[2:1], ~accIdx_q[0]};  // [R13]
      if (rdIssue) begin
        lastIdx_q   <= accIdx_q;
        presented_q <= 1'b1;
      end
    end
  end

  // Request to the core, held stable until answered
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      reqToggle <= 1'b0;
      reqWrite  <= 1'b0;
      reqIdx    <= 3'h0;
      reqData   <= 8'h00;
    end else if (wrIssue || rdIssue) begin
      reqToggle <= ~reqToggle;  // [R15]
      reqWrite  <= wrIssue;
      reqIdx    <= accIdx_q;
      reqData   <= wrByte;
    end
  end

  // Answer taken once the toggle has crossed
  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      ackSeen_q <= 1'b0;
      rdData    <= 8'h00;
      rdValid   <= 1'b0;
    end else begin
      ackSeen_q <= ack2_q;
      rdValid   <= (ack2_q != ackSeen_q) && !reqWrite;
      if ((ack2_q != ackSeen_q) && !reqWrite) begin
        rdData <= rspData;
      end
    end
  end

  assign linkBusy = (reqToggle != ackSeen_q) || (ack2_q != ackSeen_q);

  property p_cmd_to_pointer;
    @(posedge linkClk) disable iff (!linkRstN_q)
      (cmdTake && !xferStart && !xferStop) |=> (pointer_q == $past(wrByte));
  endproperty
  a_cmd_to_pointer: assert property (p_cmd_to_pointer)  // [R1]
    else $error("command byte not stored in pointer");

  property p_pair_alternates;
    @(posedge linkClk) disable iff (!linkRstN_q)
      (rdIssue && !xferStart) |=> (reqIdx[2:1] == accIdx_q[2:1])
        && (reqIdx[0] != accIdx_q[0]);
  endproperty
  a_pair_alternates: assert property (p_pair_alternates)  // [R13]
    else $error("read did not alternate within pair");

  property p_restart_pointer;
    @(posedge linkClk) disable iff (!linkRstN_q)
      (restartRead && !cmdTake) |=>
        (pointer_q[2:0] == $past(lastIdx_q)) && (accIdx_q == pointer_q[2:0]);
  endproperty
  a_restart_pointer: assert property (p_restart_pointer)  // [R14]
    else $error("restart did not move pointer");

  property p_read_keeps_pointer;
    @(posedge linkClk) disable iff (!linkRstN_q)
      (xferStart && xferRead && !restartRead) |=>
        (accIdx_q == pointer_q[2:0]);
  endproperty
  a_read_keeps_pointer: assert property (p_read_keeps_pointer)  // [R4]
    else $error("read not started at stored pointer");

  property p_ack_edge_request;
    @(posedge linkClk) disable iff (!linkRstN_q)
      rdIssue |=> (reqToggle != $past(reqToggle)) && !reqWrite;
  endproperty
  a_ack_edge_request: assert property (p_ack_edge_request)  // [R15]
    else $error("read request not launched at ack edge");

endmodule  // expander_link
`default_nettype wire

// ---- hdl/serial_io_expander_regs.sv ----
// Register core of a 16-bit serial-controlled I/O expander: eight byte
// registers, two 8-bit pin ports, and the link-side sequencer.
// Assumes a byte-level bus engine on linkClk and pins from outside clk.
`timescale 1ns/100ps
`default_nettype none
`include "serial_io_expander_regs_params.svh"

// What this block does
// [R1] First byte after a write address is stored as the pointer.
// [R2] Low three pointer bits pick one of eight registers, 0x00..0x07.
// [R3] Command bytes only come in write transfers; reads reuse pointer.
// [R4] Reads keep hitting the selected register until a new command.
// [R5] Input registers return live pin levels, inputs or outputs alike.
// [R6] Writes to input registers are dropped; no reset value there.
// [R7] Output latches at 0x02/0x03 drive output pins, reset all ones.
// [R8] Output latch bits do not touch pins set as inputs.
// [R9] Reading an output register returns the latch, not the pin.
// [R10] Polarity bits at 0x04/0x05 invert input readings, reset zero.
// [R11] Direction at 0x06/0x07: one is input, zero output; reset ones.
// [R12] Controller sets pointer by a write before reading inputs.
// [R13] Multi-byte accesses alternate between the two pair registers.
// [R14] A restart during a read moves the pointer to that register.
// [R15] Data is taken or presented at each byte's ack clock edge; reads only launch the request there, rdValid comes later.
// [R16] Controller may read any count, nacks the last, then stops.
module serial_io_expander_regs
  import serial_io_expander_pkg::*;
(
  input  wire logic        clk,         // Core clock, 20 MHz
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic        linkClk,     // Bus clock from the engine
  input  wire logic        xferStart,   // Start/restart, address acked
  input  wire logic        xferRead,    // Transfer is a read
  input  wire logic        xferStop,    // Stop condition seen
  input  wire logic        wrByteValid, // Written byte, ack edge pulse
  input  wire byte_t       wrByte,      // Written byte value
  input  wire logic        rdByteReq,   // Read byte wanted, ack edge
  input  wire logic [15:0] pinIn,       // Pin levels, asynchronous
  output byte_t            rdData,      // Read byte to the engine
  output logic             rdValid,     // rdData fresh, one pulse
  output logic             linkBusy,    // Request in flight
  output logic      [15:0] pinOut,      // Pin drive levels
  output logic      [15:0] pinOeN       // Pin enables, low drives
);

  // Link-to-core request channel
  logic    reqToggle, reqWrite;
  regIdx_t reqIdx;
  byte_t   reqData;
  logic    ackToggle_q;
  byte_t   rspData_q;

  // Core-side crossing state
  logic    req1_q, req2_q, reqSeen_q;
  logic    reqNew, wrNew, rdNew;
  logic [15:0] pin1_q, pin2_q;

  // Register file, one entry per port
  byte_t   driveLatch_q [2];
  byte_t   invertMask_q [2];
  byte_t   direction_q  [2];
  logic [15:0] levelView;
  byte_t   readMux;

  // Link-side sequencer on the bus clock
  expander_link u_link (
    .linkClk     (linkClk),
    .rst_n       (rst_n),
    .xferStart   (xferStart),
    .xferRead    (xferRead),
    .xferStop    (xferStop),
    .wrByteValid (wrByteValid),
    .wrByte      (wrByte),
    .rdByteReq   (rdByteReq),
    .ackToggle   (ackToggle_q),
    .rspData     (rspData_q),
    .reqToggle   (reqToggle),
    .reqWrite    (reqWrite),
    .reqIdx      (reqIdx),
    .reqData     (reqData),
    .rdData      (rdData),
    .rdValid     (rdValid),
    .linkBusy    (linkBusy)
  );

  // Request toggle synchroniser; payload is held stable by the sender
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req1_q    <= 1'b0;
      req2_q    <= 1'b0;
      reqSeen_q <= 1'b0;
    end else begin
      req1_q    <= reqToggle;
      req2_q    <= req1_q;
      reqSeen_q <= req2_q;
    end
  end

  assign reqNew = (req2_q != reqSeen_q);
  assign wrNew  = reqNew && reqWrite;
  assign rdNew  = reqNew && !reqWrite;

  // Pin synchroniser; pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin1_q <= `RST_PINS;
      pin2_q <= `RST_PINS;
    end else begin
      pin1_q <= pinIn;
      pin2_q <= pin1_q;
    end
  end

  // Per-port registers; input-level indices have no storage at all
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam regIdx_t IdxDrive  = `IDX_DRIVE_LATCH_LO + 3'(p);
    localparam regIdx_t IdxInvert = `IDX_INVERT_MASK_LO + 3'(p);
    localparam regIdx_t IdxDir    = `IDX_DIRECTION_LO + 3'(p);

    // Output latch
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        driveLatch_q[p] <= `RST_DRIVE_LATCH;  // [R7]
      end else if (wrNew && (reqIdx == IdxDrive)) begin
        driveLatch_q[p] <= reqData;  // [R2]
      end
    end

    // Polarity mask
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        invertMask_q[p] <= `RST_INVERT_MASK;  // [R10]
      end else if (wrNew && (reqIdx == IdxInvert)) begin
        invertMask_q[p] <= reqData;
      end
    end

    // Direction
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        direction_q[p] <= `RST_DIRECTION;  // [R11]
      end else if (wrNew && (reqIdx == IdxDir)) begin
        direction_q[p] <= reqData;
      end
    end

    // Inversion only applies to pins set as inputs
    assign levelView[8*p +: 8] =
      pin2_q[8*p +: 8] ^ (invertMask_q[p] & direction_q[p]);  // [R10]
  end

  // Pin drivers: latch always presented, enable decides; a latched
  // bit waits silently until its pin turns into an output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinOut <= {`RST_DRIVE_LATCH, `RST_DRIVE_LATCH};
      pinOeN <= {`RST_DIRECTION, `RST_DIRECTION};
    end else begin
      pinOut <= {driveLatch_q[1], driveLatch_q[0]};  // [R8]
      pinOeN <= {direction_q[1], direction_q[0]};    // [R11]
    end
  end

  // Read selection; writes to input indices fall through untouched [R6]
  always_comb begin
    unique case (reqIdx)
      `IDX_PIN_LEVEL_LO:   readMux = levelView[7:0];   // [R5]
      `IDX_PIN_LEVEL_HI:   readMux = levelView[15:8];  // [R5]
      `IDX_DRIVE_LATCH_LO: readMux = driveLatch_q[0];  // [R9]
      `IDX_DRIVE_LATCH_HI: readMux = driveLatch_q[1];  // [R9]
      `IDX_INVERT_MASK_LO: readMux = invertMask_q[0];
      `IDX_INVERT_MASK_HI: readMux = invertMask_q[1];
      `IDX_DIRECTION_LO:   readMux = direction_q[0];
      `IDX_DIRECTION_HI:   readMux = direction_q[1];
    endcase
  end

  // Answer: data and toggle in the same cycle; the link side only
  // samples the data after two more of its own edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rspData_q   <= 8'h00;
      ackToggle_q <= 1'b0;
    end else if (reqNew) begin
      ackToggle_q <= ~ackToggle_q;
      if (rdNew) begin
        rspData_q <= readMux;  // [R15]
      end
    end
  end

  property p_reset_values;
    @(posedge clk)
      !rst_n |=> (driveLatch_q[0] == 8'hff) && (driveLatch_q[1] == 8'hff)
        && (invertMask_q[0] == 8'h00) && (invertMask_q[1] == 8'h00)
        && (direction_q[0] == 8'hff) && (direction_q[1] == 8'hff);
  endproperty
  a_reset_values: assert property (p_reset_values)  // [R7]
    else $error("register reset values wrong");

  property p_write_decode;
    @(posedge clk) disable iff (!rst_n)
      (wrNew && (reqIdx == 3'h3)) |=>
        (driveLatch_q[1] == $past(reqData))
        && $stable(driveLatch_q[0]) && $stable(direction_q[1]);
  endproperty
  a_write_decode: assert property (p_write_decode)  // [R2]
    else $error("write hit wrong register");

  property p_input_write_dropped;
    @(posedge clk) disable iff (!rst_n)
      (wrNew && (reqIdx[2:1] == 2'b00)) |=>
        $stable(driveLatch_q[0]) && $stable(driveLatch_q[1])
        && $stable(invertMask_q[0]) && $stable(invertMask_q[1])
        && $stable(direction_q[0]) && $stable(direction_q[1]);
  endproperty
  a_input_write_dropped: assert property (p_input_write_dropped)  // [R6]
    else $error("write to input register changed state");

  property p_input_read_live;
    @(posedge clk) disable iff (!rst_n)
      (rdNew && (reqIdx == 3'h0)) |=>
        (rspData_q == ($past(pin2_q[7:0])
          ^ ($past(invertMask_q[0]) & $past(direction_q[0]))));
  endproperty
  a_input_read_live: assert property (p_input_read_live)  // [R5]
    else $error("input read does not follow pin level");

  property p_invert_high;
    @(posedge clk) disable iff (!rst_n)
      (rdNew && (reqIdx == 3'h1) && (invertMask_q[1] == 8'hff)
        && (direction_q[1] == 8'hff)) |=>
        (rspData_q == ~$past(pin2_q[15:8]));
  endproperty
  a_invert_high: assert property (p_invert_high)  // [R10]
    else $error("polarity inversion not applied");

  property p_latch_read;
    @(posedge clk) disable iff (!rst_n)
      (rdNew && (reqIdx == 3'h2)) |=> (rspData_q == $past(driveLatch_q[0]));
  endproperty
  a_latch_read: assert property (p_latch_read)  // [R9]
    else $error("output read not from latch");

  property p_input_pin_released;
    @(posedge clk) disable iff (!rst_n)
      ##1 (pinOeN[7:0] == $past(direction_q[0]))
        && (pinOeN[15:8] == $past(direction_q[1]));
  endproperty
  a_input_pin_released: assert property (p_input_pin_released)  // [R8]
    else $error("input pin driver not released");

  property p_direction_write;
    @(posedge clk) disable iff (!rst_n)
      (wrNew && (reqIdx == 3'h6)) |=> ##1 (pinOeN[7:0] == $past(reqData, 2));
  endproperty
  a_direction_write: assert property (p_direction_write)  // [R11]
    else $error("direction write not on pin enables");

  property p_one_answer;
    @(posedge clk) disable iff (!rst_n)
      reqNew |=> !reqNew ##0 (ackToggle_q != $past(ackToggle_q));
  endproperty
  a_one_answer: assert property (p_one_answer)  // [R15]
    else $error("request not answered exactly once");

endmodule  // serial_io_expander_regs
`default_nettype wire

// ---- inc/serial_io_expander_pkg.sv ----
// Types shared by the expander register core and its link side.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_io_expander_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] regIdx_t;
  // Transfer phase seen on the link side
  typedef enum logic [3:0] {
    PH_IDLE  = 4'b0001,
    PH_CMD   = 4'b0010,
    PH_WRITE = 4'b0100,
    PH_READ  = 4'b1000
  } phase_e;
endpackage

// ---- inc/serial_io_expander_regs_params.svh ----
// Constants for the I/O expander register core: register indices,
// pointer field layout and reset values.
// Assumes it is included by bare name from design files.
`ifndef SERIAL_IO_EXPANDER_REGS_PARAMS_SVH
`define SERIAL_IO_EXPANDER_REGS_PARAMS_SVH

// Register indices selected by the low pointer bits
`define IDX_PIN_LEVEL_LO   3'h0
`define IDX_PIN_LEVEL_HI   3'h1
`define IDX_DRIVE_LATCH_LO 3'h2
`define IDX_DRIVE_LATCH_HI 3'h3
`define IDX_INVERT_MASK_LO 3'h4
`define IDX_INVERT_MASK_HI 3'h5
`define IDX_DIRECTION_LO   3'h6
`define IDX_DIRECTION_HI   3'h7

// Pointer field: index bits pointer_bit_two..pointer_bit_zero
`define PTR_IDX_MSB 2
`define PTR_IDX_LSB 0

// Reset values
`define RST_DRIVE_LATCH 8'hff
`define RST_INVERT_MASK 8'h00
`define RST_DIRECTION   8'hff
`define RST_POINTER     8'h00
`define RST_PINS        16'h0000

`endif

// ---- verif/expander_ctl_model.sv ----
// Byte-level bus controller model on the far side of the expander link.
// Assumes the expander's link ports; makes linkClk only inside frames.
`timescale 1ns/100ps
`default_nettype none

module expander_ctl_model
  import serial_io_expander_pkg::*;
(
  output logic       linkClk,     // Link clock, stands still when idle
  output logic       xferStart,   // Start or restart pulse
  output logic       xferRead,    // Direction with xferStart
  output logic       xferStop,    // Stop pulse
  output logic       wrByteValid, // Written byte pulse
  output byte_t      wrByte,      // Written byte
  output logic       rdByteReq,   // Read byte request pulse
  input  wire logic  linkBusy,    // Request in flight
  input  wire byte_t rdData,      // Read byte
  input  wire logic  rdValid      // Read byte fresh
);
  logic run;

  // Idle values at time zero
  initial begin
    run         = 1'b0;
    linkClk     = 1'b0;
    xferStart   = 1'b0;
    xferRead    = 1'b0;
    xferStop    = 1'b0;
    wrByteValid = 1'b0;
    wrByte      = 8'h00;
    rdByteReq   = 1'b0;
  end

  // Clock halts low between frames, so no stray edges reach the link
  always begin
    #62.5;
    if (run || linkClk) linkClk = ~linkClk;
  end

  // Wait for the link to accept; bounded so a stuck busy cannot hang
  task automatic idle();
    int n;
    n = 0;
    @(posedge linkClk);
    while (linkBusy !== 1'b0 && n < 200) begin
      @(posedge linkClk);
      n++;
    end
  endtask

  // Start or repeated start; direction only valid with the pulse
  task automatic start(input logic rd);
    run = 1'b1;
    idle();
    xferStart <= 1'b1;
    xferRead  <= rd;
    @(posedge linkClk);
    xferStart <= 1'b0;
    xferRead  <= ~rd;
  endtask

  // First byte of a write frame is the command byte
  task automatic wr(input byte_t b);
    idle();
    wrByteValid <= 1'b1;
    wrByte      <= b;
    @(posedge linkClk);
    wrByteValid <= 1'b0;
    wrByte      <= ~b; // Released line shows no stale data
    repeat (2) @(posedge linkClk);
  endtask

  // Read frames carry no command byte
  task automatic rd(output byte_t d);
    int n;
    d = 8'hxx;
    idle();
    rdByteReq <= 1'b1;
    @(posedge linkClk);
    rdByteReq <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge linkClk);
      if (rdValid === 1'b1) begin
        d = rdData;
        break;
      end
    end
  endtask

  // Wait for idle, pulse stop, two more edges, then the clock halts
  task automatic stop();
    idle();
    xferStop <= 1'b1;
    @(posedge linkClk);
    xferStop <= 1'b0;
    repeat (2) @(posedge linkClk);
    run = 1'b0;
  endtask
endmodule // expander_ctl_model

`default_nettype wire

// ---- verif/serial_io_expander_regs_tb_top.sv ----
// Self-checking bench for the expander register core.
// Assumes the controller model drives the link side.
`timescale 1ns/100ps
`default_nettype none
`include "serial_io_expander_regs_params.svh"

module serial_io_expander_regs_tb_top
  import serial_io_expander_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [15:0] pinIn;
  logic [15:0] pinHold;
  wire logic   linkClk, xferStart, xferRead, xferStop;
  wire logic   wrByteValid, rdByteReq, rdValid, linkBusy;
  wire byte_t  wrByte, rdData;
  wire logic [15:0] pinOut, pinOeN;
  byte_t       regModel [8];
  int          seed, n_mismatch, samples_checked, cycleCount, k;

  serial_io_expander_regs DUT (
    .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .xferStart(xferStart),
    .xferRead(xferRead), .xferStop(xferStop), .wrByteValid(wrByteValid),
    .wrByte(wrByte), .rdByteReq(rdByteReq), .pinIn(pinIn),
    .rdData(rdData), .rdValid(rdValid), .linkBusy(linkBusy),
    .pinOut(pinOut), .pinOeN(pinOeN));

  expander_ctl_model u_ctl (
    .linkClk(linkClk), .xferStart(xferStart), .xferRead(xferRead),
    .xferStop(xferStop), .wrByteValid(wrByteValid), .wrByte(wrByte),
    .rdByteReq(rdByteReq), .linkBusy(linkBusy), .rdData(rdData),
    .rdValid(rdValid));

  // Core clock, 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inversion only on pins set as inputs
  function automatic byte_t expRd(input regIdx_t i);
    logic [15:0] p;
    p = pinHold ^ ({regModel[5], regModel[4]} & {regModel[7], regModel[6]});
    if (i == `IDX_PIN_LEVEL_LO) return p[7:0];
    if (i == `IDX_PIN_LEVEL_HI) return p[15:8];
    return regModel[i];
  endfunction

  // Pins change only between frames, then settle through the syncs
  task automatic setPins(input logic [15:0] v);
    @(posedge clk);
    pinIn <= v;
    pinHold = v;
    repeat (4) @(posedge clk);
  endtask

  task automatic chkPins();
    chk(pinOut, {regModel[3], regModel[2]});
    chk(pinOeN, {regModel[7], regModel[6]});
  endtask

  // Writes to the input pair leave the model untouched
  task automatic wrPair(input regIdx_t i, input byte_t a, input byte_t b);
    u_ctl.start(1'b0);
    u_ctl.wr({5'h00, i});
    u_ctl.wr(a);
    u_ctl.wr(b);
    u_ctl.stop();
    if (i > 3'h1) begin
      regModel[i] = a;
      regModel[i ^ 3'h1] = b;
    end
    repeat (4) @(posedge clk);
  endtask

  // Reads inside an open read frame, alternating within the pair
  task automatic rdChk(input regIdx_t i, input int cnt);
    byte_t d;
    regIdx_t r;
    r = i;
    repeat (cnt) begin
      u_ctl.rd(d);
      chk({8'h00, d}, {8'h00, expRd(r)});
      r = r ^ 3'h1;
    end
  endtask

  task automatic rdFrame(input regIdx_t i, input int cnt);
    u_ctl.start(1'b0);
    u_ctl.wr({5'h00, i});
    u_ctl.start(1'b1);
    rdChk(i, cnt);
    u_ctl.stop();
  endtask

  initial begin
    seed = 89;
    rst_n = 1'b0;
    pinIn = 16'h0000;
    pinHold = 16'h0000;
    n_mismatch = 0;
    samples_checked = 0;
    cycleCount = 0;
    regModel[2] = `RST_DRIVE_LATCH;
    regModel[3] = `RST_DRIVE_LATCH;
    regModel[4] = `RST_INVERT_MASK;
    regModel[5] = `RST_INVERT_MASK;
    regModel[6] = `RST_DIRECTION;
    regModel[7] = `RST_DIRECTION;
    // Both domains must see reset edges before release
    u_ctl.run = 1'b1;
    repeat (6) @(posedge clk);
    repeat (3) @(posedge linkClk);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge linkClk);
    u_ctl.run = 1'b0;
    setPins(16'($random(seed)));
    chkPins();
    for (k = 0; k < 8; k++) rdFrame(3'(k), 2);
    // Random traffic across all writable pairs
    repeat (8) begin
      setPins(16'($random(seed)));
      wrPair(3'(2 + $unsigned($random(seed)) % 6), 8'($random(seed)),
             8'($random(seed)));
      chkPins();
      rdFrame(3'($unsigned($random(seed)) % 8), 3);
    end
    // Input pair writes are dropped
    wrPair(3'h0, 8'h5a, 8'ha5);
    wrPair(3'h1, 8'h3c, 8'hc3);
    chkPins();
    rdFrame(3'h2, 2);
    rdFrame(3'h6, 2);
    // Outputs read back the latch while pins disagree; inversion gated
    wrPair(3'h6, 8'h00, 8'h00);
    wrPair(3'h2, 8'h96, 8'h69);
    wrPair(3'h4, 8'hff, 8'hff);
    setPins(~{regModel[3], regModel[2]});
    chkPins();
    rdFrame(3'h3, 2);
    rdFrame(3'h0, 2);
    wrPair(3'h7, 8'hff, 8'hff);
    rdFrame(3'h1, 2);
    // Pointer kept across command-less read frames
    rdFrame(3'h5, 1);
    repeat (2) begin
      u_ctl.start(1'b1);
      rdChk(3'h5, 1);
      u_ctl.stop();
    end
    // Restart after reading lo then hi resumes at hi
    u_ctl.start(1'b0);
    u_ctl.wr(8'h00);
    u_ctl.start(1'b1);
    rdChk(3'h0, 2);
    u_ctl.start(1'b1);
    rdChk(3'h1, 1);
    u_ctl.stop();
    end_sim();
  end
endmodule // serial_io_expander_regs_tb_top

`default_nettype wire
